// ---- include/scaling_consts.vh ----
// Constants shared by the analog input scaling curve design files.
`ifndef SCALING_CONSTS_VH
`define SCALING_CONSTS_VH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TICK_TIME_NS   5000000
`define CLK_PERIOD_NS  10
// Filter time constant and update period are counted in 5 ms steps.
`define TAU_RESET      20'h000C8
`define PERIOD_RESET   16'h001E

// ---------------------------------------------------------------
// Fixed-point scale: one unit is 100000 counts of 0.00001
// ---------------------------------------------------------------
`define ONE_UNIT       32'sh000186A0

// ---------------------------------------------------------------
// Register word addresses
// ---------------------------------------------------------------
`define A_GCTRL        9'h000
`define A_IRQ_STAT     9'h001
`define A_IRQ_CLR      9'h002
`define A_IRQ_EN       9'h003
`define A_FAULTS       9'h004
`define O_CTRL         6'h00
`define O_TAU          6'h01
`define O_PERIOD       6'h02
`define O_MIN          6'h03
`define O_MAX          6'h04
`define O_PTEN         6'h05
`define O_INPUT        6'h06
`define O_OUTPUT       6'h07
`define O_PX           6'h10
`define O_PX_END       6'h24
`define O_PY           6'h28
`define O_PY_END       6'h3C

// ---------------------------------------------------------------
// Curve control fields and codes
// ---------------------------------------------------------------
`define C_EN           0
`define C_FILT         1
`define C_RNG          2
`define C_RND          4:3
`define C_SEL          13:8
`define SEL_LAST       6'h29
`define RND_FLOOR      2'h1
`define RND_CEIL       2'h2
`define RND_NEAR       2'h3
`define LAST_POINT     5'h13

`endif

// ---- verilog/div_seq.v ----
// Sequential signed divider, one quotient bit per clock.
`timescale 1ns/1ps
module div_seq #(
    parameter NW = 66,
    parameter DW = 33
) (
    // Clock and reset
    input  wire                 clk_sys,
    input  wire                 reset_n,
    // Request
    input  wire                 start,
    input  wire signed [NW-1:0] num,
    input  wire signed [DW-1:0] den,
    // Answer
    output reg                  done,
    output wire        [NW-1:0] quo
);
    localparam [31:0] STEPS_W = NW;
    localparam [6:0]  STEPS   = STEPS_W[6:0];

    reg  [NW-1:0] n;
    reg  [DW-1:0] d;
    reg  [DW-1:0] rem;
    reg  [6:0]    cnt;
    reg           busy;
    reg           neg;
    wire [NW-1:0] nabs  = num[NW-1] ? -num : num;
    wire [DW-1:0] dabs  = den[DW-1] ? -den : den;
    wire [DW:0]   trial = {rem, n[NW-1]} - {1'b0, d};

    assign quo = neg ? -n : n;

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            n    <= {NW{1'b0}};
            d    <= {DW{1'b0}};
            rem  <= {DW{1'b0}};
            cnt  <= 7'h00;
            busy <= 1'b0;
            neg  <= 1'b0;
            done <= 1'b0;
        end
        else if (start)
        begin
            n    <= nabs;
            d    <= dabs;
            rem  <= {DW{1'b0}};
            cnt  <= STEPS;
            busy <= 1'b1;
            neg  <= num[NW-1] ^ den[DW-1];
            done <= 1'b0;
        end
        else if (busy)
        begin
            n    <= {n[NW-2:0], ~trial[DW]};
            rem  <= trial[DW] ? {rem[DW-2:0], n[NW-1]} : trial[DW-1:0];
            cnt  <= cnt - 7'h01;
            busy <= (cnt != 7'h01);
            done <= (cnt == 7'h01);
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule // div_seq

// ---- verilog/round_unit.v ----
// Rounding of a scaled value to whole units.
`timescale 1ns/1ps
`include "scaling_consts.vh"
module round_unit (
    // Value and rounding code
    input  wire signed [31:0] value,
    input  wire        [1:0]  mode,
    // Rounded value
    output reg  signed [31:0] result
);
    wire signed [31:0] q = value / `ONE_UNIT;
    wire signed [31:0] r = value - q * `ONE_UNIT;
    wire signed [31:0] r2 = r + r;

    always @*
    begin
        case (mode)
        `RND_FLOOR: result = ((r < 0) ? q - 1 : q) * `ONE_UNIT;
        `RND_CEIL:  result = ((r > 0) ? q + 1 : q) * `ONE_UNIT;
        `RND_NEAR:  result = ((r2 >= `ONE_UNIT) ? q + 1 :
                              (r2 <= -`ONE_UNIT) ? q - 1 : q) * `ONE_UNIT;
        default:    result = value;
        endcase
    end
endmodule // round_unit

// ---- verilog/analog_input_scaling.v ----
// Four analog input scaling curves with Avalon-MM register access.
//
// How it works
// - A master enable stops every curve from processing and reporting.
// - Each curve enable stops its calculation and its input sampling.
// - Selector: 0-3 slot mA, 4-23 DI volts, 24-39 RTD, 40-41 card mA.
// - With filtering on, a running average replaces the raw sample.
// - Filter time constant counts 5 ms steps, default 1 s.
// - The average is a unity-gain first-order low-pass.
// - Range flag is set below minimum or above maximum when enabled.
// - Minimum and maximum are signed, 0.00001 resolution, reset zero.
// - Each range flag is a binary output for logic, relays and LEDs.
// - A lost input keeps the last valid sample.
// - Input is refreshed once per update period, 5 ms steps, 150 ms.
// - Rounding code: 0 none, 1 floor, 2 ceiling, 3 nearest.
// - Two default points pair inputs zero and one with outputs.
// - Point outputs are signed, 0.00001 resolution, reset zero.
// - Points 3 to 20 are enabled one by one.
// - The present input of each curve can be read back.
// - The present output of each curve is readable and an output.
`timescale 1ns/1ps
`include "scaling_consts.vh"
module analog_input_scaling #(
    parameter TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire           clk_sys,
    input  wire           reset_n,
    // Avalon-MM register slave
    input  wire [8:0]     address,
    input  wire           read,
    input  wire           write,
    input  wire [31:0]    writedata,
    output reg  [31:0]    readdata,
    output reg            waitrequest,
    output reg            irq,
    // Measurement sources, 42 words of signed 0.00001 units
    input  wire [1343:0]  source_data,
    input  wire [41:0]    source_valid,
    // Curve results
    output reg  [127:0]   curve_value,
    output reg  [3:0]     curve_input_range_fault
);
    localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
    localparam [19:0] TICK_LAST   = TICK_LAST_W[19:0];
    localparam [2:0]  S_IDLE  = 3'h0;
    localparam [2:0]  S_PICK  = 3'h1;
    localparam [2:0]  S_FILT  = 3'h2;
    localparam [2:0]  S_FWAIT = 3'h3;
    localparam [2:0]  S_SCAN  = 3'h4;
    localparam [2:0]  S_IWAIT = 3'h5;
    localparam [2:0]  S_FIN   = 3'h6;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    reg signed [31:0] px [0:79];
    reg signed [31:0] py [0:79];
    reg        [13:0] ctrl [0:3];
    reg        [19:0] tau [0:3];
    reg        [15:0] per [0:3];
    reg signed [31:0] minv [0:3];
    reg signed [31:0] maxv [0:3];
    reg        [19:0] pten [0:3];
    reg signed [31:0] sample [0:3];
    reg signed [31:0] filt [0:3];
    reg        [15:0] pcnt [0:3];
    reg               master_en;
    reg        [7:0]  irq_status;
    reg        [7:0]  irq_enable;
    reg        [7:0]  event_bits;
    reg        [31:0] next_readdata;
    reg        [19:0] tick_cnt;
    reg               tick;
    reg        [2:0]  state;
    reg        [1:0]  cur;
    reg        [4:0]  idx;
    reg        [4:0]  prev;
    reg               have_prev;
    reg signed [31:0] xv;
    reg signed [31:0] y0;
    reg signed [31:0] yres;
    reg               div_start;
    reg signed [65:0] div_num;
    reg signed [32:0] div_den;
    integer           k;
    integer           j;

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    wire       req      = (read | write) & waitrequest;
    wire       wr_fire  = write & ~waitrequest;
    wire [2:0] blk      = address[8:6];
    wire [2:0] wcb      = blk - 3'h1;
    wire [1:0] wc       = wcb[1:0];
    wire       in_curve = (blk != 3'h0) && (blk <= 3'h4);
    wire [5:0] off      = address[5:0];
    wire       is_px    = (off >= `O_PX) && (off < `O_PX_END);
    wire       is_py    = (off >= `O_PY) && (off < `O_PY_END);
    wire [6:0] wbase    = {1'b0, wc, 4'h0} + {3'h0, wc, 2'h0};
    wire [5:0] pxo      = off - `O_PX;
    wire [5:0] pyo      = off - `O_PY;
    wire [6:0] wpx      = wbase + {1'b0, pxo};
    wire [6:0] wpy      = wbase + {1'b0, pyo};
    wire [7:0] clr_mask = (wr_fire && address == `A_IRQ_CLR) ?
                          writedata[7:0] : 8'h00;

    always @*
    begin
        next_readdata = 32'h0;
        if (address == `A_GCTRL)
            next_readdata = {31'h0, master_en};
        else if (address == `A_IRQ_STAT)
            next_readdata = {24'h0, irq_status};
        else if (address == `A_IRQ_EN)
            next_readdata = {24'h0, irq_enable};
        else if (address == `A_FAULTS)
            next_readdata = {28'h0, curve_input_range_fault};
        else if (in_curve)
        begin
            case (off)
            `O_CTRL:   next_readdata = {18'h0, ctrl[wc]};
            `O_TAU:    next_readdata = {12'h0, tau[wc]};
            `O_PERIOD: next_readdata = {16'h0, per[wc]};
            `O_MIN:    next_readdata = minv[wc];
            `O_MAX:    next_readdata = maxv[wc];
            `O_PTEN:   next_readdata = {12'h0, pten[wc][19:2], 2'h3};
            `O_INPUT:  next_readdata = filt[wc];
            `O_OUTPUT: next_readdata = curve_value[{wc, 5'h0} +: 32];
            default:
            begin
                if (is_px)
                    next_readdata = px[wpx];
                else if (is_py)
                    next_readdata = py[wpy];
            end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Bus slave, settings and interrupt
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
            irq         <= 1'b0;
            master_en   <= 1'b0;
            irq_status  <= 8'h00;
            irq_enable  <= 8'h00;
            for (k = 0; k < 4; k = k + 1)
            begin
                ctrl[k] <= 14'h0;
                tau[k]  <= `TAU_RESET;
                per[k]  <= `PERIOD_RESET;
                minv[k] <= 32'sh0;
                maxv[k] <= 32'sh0;
                pten[k] <= 20'h0;
            end
            for (k = 0; k < 80; k = k + 1)
            begin
                px[k] <= (k % 20 == 1) ? `ONE_UNIT : 32'sh0;
                py[k] <= 32'sh0;
            end
        end
        else
        begin
            waitrequest <= ~req;
            if (req)
                readdata <= next_readdata;
            irq_status <= (irq_status & ~clr_mask) | event_bits;
            irq <= |(irq_status & irq_enable);
            if (wr_fire)
            begin
                if (address == `A_GCTRL)
                    master_en <= writedata[0];
                if (address == `A_IRQ_EN)
                    irq_enable <= writedata[7:0];
                if (in_curve)
                begin
                    case (off)
                    `O_CTRL:   ctrl[wc] <= writedata[13:0];
                    `O_TAU:    tau[wc]  <= writedata[19:0];
                    `O_PERIOD: per[wc]  <= writedata[15:0];
                    `O_MIN:    minv[wc] <= writedata;
                    `O_MAX:    maxv[wc] <= writedata;
                    `O_PTEN:   pten[wc] <= {writedata[19:2], 2'h0};
                    default:
                    begin
                        if (is_px)
                            px[wpx] <= writedata;
                        else if (is_py)
                            py[wpy] <= writedata;
                    end
                    endcase
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Processing tick
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_cnt <= 20'h0;
            tick     <= 1'b0;
        end
        else
        begin
            tick     <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? 20'h0 :
                        tick_cnt + 20'h1;
        end
    end

    // ---------------------------------------------------------------
    // Datapath helpers
    // ---------------------------------------------------------------
    wire [6:0]  base   = {1'b0, cur, 4'h0} + {3'h0, cur, 2'h0};
    wire [6:0]  pi     = base + {2'h0, idx};
    wire [6:0]  pp     = base + {2'h0, prev};
    wire signed [31:0] pxi = px[pi];
    wire signed [31:0] pxp = px[pp];
    wire signed [31:0] pyi = py[pi];
    wire signed [31:0] pyp = py[pp];
    wire signed [32:0] dy  = {pyi[31], pyi} - {pyp[31], pyp};
    wire signed [32:0] dxa = {xv[31], xv} - {pxp[31], pxp};
    wire signed [32:0] dxs = {pxi[31], pxi} - {pxp[31], pxp};
    wire signed [65:0] prod = dy * dxa;
    wire signed [31:0] s_c = sample[cur];
    wire signed [31:0] f_c = filt[cur];
    wire signed [32:0] fd  = {s_c[31], s_c} - {f_c[31], f_c};
    wire [19:0] tau_c  = (tau[cur] == 20'h0) ? 20'h1 : tau[cur];
    wire        pen    = (idx < 5'h2) | pten[cur][idx];
    wire [5:0]  sel    = ctrl[cur][`C_SEL];
    wire        sel_ok = (sel <= `SEL_LAST) && source_valid[sel];
    wire [15:0] pnext  = pcnt[cur] + 16'h1;
    wire        due    = (pnext >= per[cur]);
    wire        run    = master_en & ctrl[cur][`C_EN];
    wire        out_rng = ctrl[cur][`C_RNG] &&
                          (xv < minv[cur] || xv > maxv[cur]);
    wire        div_done;
    wire [65:0] div_quo;
    wire [31:0] quo32  = div_quo[31:0];
    wire signed [31:0] rounded;

    div_seq #(
        .NW (66),
        .DW (33)
    ) u_div (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .start   (div_start),
        .num     (div_num),
        .den     (div_den),
        .done    (div_done),
        .quo     (div_quo)
    );

    round_unit u_round (
        .value  (yres),
        .mode   (ctrl[cur][`C_RND]),
        .result (rounded)
    );

    // ---------------------------------------------------------------
    // Curve sequencer, one pass over all curves per tick
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state       <= S_IDLE;
            cur         <= 2'h0;
            idx         <= 5'h0;
            prev        <= 5'h0;
            have_prev   <= 1'b0;
            xv          <= 32'sh0;
            y0          <= 32'sh0;
            yres        <= 32'sh0;
            div_start   <= 1'b0;
            div_num     <= 66'sh0;
            div_den     <= 33'sh1;
            event_bits  <= 8'h00;
            curve_value <= 128'h0;
            curve_input_range_fault <= 4'h0;
            for (j = 0; j < 4; j = j + 1)
            begin
                sample[j] <= 32'sh0;
                filt[j]   <= 32'sh0;
                pcnt[j]   <= 16'h0;
            end
        end
        else
        begin
            div_start  <= 1'b0;
            event_bits <= 8'h00;
            case (state)
            S_IDLE:
            begin
                cur <= 2'h0;
                if (tick)
                    state <= S_PICK;
            end
            S_PICK:
            begin
                if (run)
                begin
                    pcnt[cur] <= due ? 16'h0 : pnext;
                    if (due && sel_ok)
                        sample[cur] <= source_data[{sel, 5'h0} +: 32];
                    state <= S_FILT;
                end
                else
                begin
                    curve_input_range_fault[cur] <= 1'b0;
                    cur <= cur + 2'h1;
                    if (cur == 2'h3)
                        state <= S_IDLE;
                end
            end
            S_FILT:
            begin
                idx       <= 5'h0;
                have_prev <= 1'b0;
                if (ctrl[cur][`C_FILT])
                begin
                    div_num   <= {{33{fd[32]}}, fd};
                    div_den   <= {13'h0, tau_c};
                    div_start <= 1'b1;
                    state     <= S_FWAIT;
                end
                else
                begin
                    filt[cur] <= s_c;
                    xv        <= s_c;
                    state     <= S_SCAN;
                end
            end
            S_FWAIT:
            begin
                if (div_done)
                begin
                    filt[cur] <= f_c + quo32;
                    xv        <= f_c + quo32;
                    state     <= S_SCAN;
                end
            end
            S_SCAN:
            begin
                idx <= idx + 5'h1;
                if (pen && xv <= pxi)
                begin
                    if (!have_prev)
                    begin
                        yres  <= pyi;
                        state <= S_FIN;
                    end
                    else
                    begin
                        div_num   <= prod;
                        div_den   <= dxs;
                        div_start <= 1'b1;
                        y0        <= pyp;
                        state     <= S_IWAIT;
                    end
                end
                else
                begin
                    if (pen)
                    begin
                        prev      <= idx;
                        have_prev <= 1'b1;
                    end
                    if (idx == `LAST_POINT)
                    begin
                        yres  <= pen ? pyi : pyp;
                        state <= S_FIN;
                    end
                end
            end
            S_IWAIT:
            begin
                if (div_done)
                begin
                    yres  <= y0 + quo32;
                    state <= S_FIN;
                end
            end
            S_FIN:
            begin
                curve_value[{cur, 5'h0} +: 32] <= rounded;
                curve_input_range_fault[cur] <= out_rng;
                event_bits[cur] <= out_rng &
                                   ~curve_input_range_fault[cur];
                event_bits[{1'b1, cur}] <= 1'b1;
                cur <= cur + 2'h1;
                state <= (cur == 2'h3) ? S_IDLE : S_PICK;
            end
            default:
            begin
                state <= S_IDLE;
            end
            endcase
        end
    end
endmodule // analog_input_scaling

// ---- dv/scaling_assertions.sv ----
// Bus, interrupt and result timing checks of the scaling block.
`timescale 1ns/1ps
`include "scaling_consts.vh"
module scaling_assertions #(
    parameter TICK_CYCLES = 400
) (
    // Clock and reset
    input wire         clk_sys,
    input wire         reset_n,
    // Register bus
    input wire [8:0]   address,
    input wire         read,
    input wire         write,
    input wire [31:0]  writedata,
    input wire [31:0]  readdata,
    input wire         waitrequest,
    input wire         irq,
    // Curve results
    input wire [127:0] curve_value,
    input wire [3:0]   curve_input_range_fault
);
    // Results may only move in the processing stretch after each tick.
    localparam int WIN = TICK_CYCLES * 9 / 10;
    integer    phase;
    reg [31:0] en_copy;

    always @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
            phase <= 0;
        else
            phase <= (phase == TICK_CYCLES - 1) ? 0 : phase + 1;

    always @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
            en_copy <= 32'h0;
        else if (write && !waitrequest && address == `A_IRQ_EN)
            en_copy <= {24'h0, writedata[7:0]};

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_taken;
        (read || write) && waitrequest;
    endsequence
    sequence s_mask_all;
        write && !waitrequest && address == `A_IRQ_EN && writedata == 32'h0;
    endsequence

    chk_answer_next: assert property (s_taken |=> !waitrequest)
        else $error("request not answered in the next cycle");
    chk_answer_once: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_idle_wait: assert property (!(read || write) && waitrequest
        |=> waitrequest) else $error("answer without a request");
    chk_read_hold: assert property (waitrequest |-> $stable(readdata))
        else $error("readdata moved outside an answer");
    chk_irq_cause: assert property (irq |-> $past(en_copy) != 32'h0)
        else $error("irq high with every source disabled");
    chk_irq_masked: assert property (s_mask_all |-> ##2 !irq)
        else $error("irq still high after masking");
    chk_value_window: assert property (
        !$stable(curve_value) |-> phase < WIN)
        else $error("curve value moved outside processing");
    chk_fault_window: assert property (
        !$stable(curve_input_range_fault) |-> phase < WIN)
        else $error("range flag moved outside processing");
endmodule // scaling_assertions

bind analog_input_scaling scaling_assertions #(
    .TICK_CYCLES(TICK_CYCLES)
) i_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .curve_value(curve_value),
    .curve_input_range_fault(curve_input_range_fault)
);

// ---- dv/tb_top.sv ----
// Self-checking bench of the analog input scaling block.
`timescale 1ns/1ps
`include "scaling_consts.vh"
module tb_top;
    localparam TICK = 400;
    reg               clk_sys = 1'b0;
    reg               reset_n = 1'b0;
    reg        [8:0]  address = 9'h000;
    reg               read = 1'b0;
    reg               write = 1'b0;
    reg        [31:0] writedata = 32'h0;
    wire       [31:0] readdata;
    wire              waitrequest;
    wire              irq;
    reg      [1343:0] source_data = 1344'h0;
    reg        [41:0] source_valid = 42'h3FFFFFFFFFF;
    wire      [127:0] curve_value;
    wire        [3:0] curve_input_range_fault;
    reg signed [31:0] x, y2, y3, rd;
    reg         [1:0] rnd;
    integer           bad_count = 0, total_checks = 0, cycles = 0, i, sel;

    always #5 clk_sys = ~clk_sys;

    analog_input_scaling #(.TICK_CYCLES(TICK)) i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .source_data(source_data), .source_valid(source_valid),
        .curve_value(curve_value),
        .curve_input_range_fault(curve_input_range_fault)
    );

    task check(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge.
    task acc(input wr, input [8:0] a, input [31:0] d);
        begin
            address <= a;
            read <= !wr;
            write <= wr;
            writedata <= d;
            @(posedge clk_sys);
            while (waitrequest !== 1'b0)
                @(posedge clk_sys);
            rd = readdata;
            read <= 1'b0;
            write <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task rchk(input [8:0] a, input [31:0] e);
        begin
            acc(0, a, 32'h0);
            check(rd, e);
        end
    endtask

    task wt(input integer n);
        repeat (n * TICK) @(posedge clk_sys);
    endtask

    // Points 0/0, 1/y2 and 2/y3, clamped at both ends, then rounded.
    function [31:0] model(input signed [31:0] v, input [1:0] m);
        reg signed [63:0] r, q, u;
        begin
            u = `ONE_UNIT;
            r = v <= 0 ? 0 : v >= 2 * u ? y3 : v >= u ?
                y2 + (v - u) * (y3 - y2) / u : v * y2 / u;
            q = r / u;
            if (m == 1 && r < 0 && q * u != r)
                q = q - 1;
            if (m == 2 && r > 0 && q * u != r)
                q = q + 1;
            if (m == 3)
                q = (r + (r < 0 ? -u / 2 : u / 2)) / u;
            model = m == 0 ? r : q * u;
        end
    endfunction

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            bad_count = bad_count + 1;
            print_verdict;
        end
    end

    initial
    begin
        i = $urandom(32'h9C39);
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        acc(1, 9'h047, 32'h1234);
        rchk(9'h041, 32'hC8);
        rchk(9'h042, 32'h1E);
        rchk(9'h043, 32'h0);
        rchk(9'h051, 32'h186A0);
        rchk(9'h069, 32'h0);
        rchk(9'h010, 32'h0);
        rchk(9'h047, 32'h0);
        for (i = 0; i < 42; i = i + 1)
            source_data[32*i +: 32] <= $urandom;
        acc(1, `A_GCTRL, 32'h1);
        acc(1, 9'h042, 32'h1);
        acc(1, 9'h044, 32'h249F0);
        acc(1, 9'h045, 32'h4);
        acc(1, 9'h052, 32'h30D40);
        acc(1, `A_IRQ_EN, 32'h10);
        for (i = 0; i < 8; i = i + 1)
        begin
            sel = i == 0 ? 24 : i == 1 ? 41 : i == 2 ? 0 : $urandom % 42;
            x = $urandom % 32'h493E0 - 32'hC350;
            y2 = $urandom % 32'h1E8480 - 32'hF4240;
            y3 = $urandom % 32'h1E8480 - 32'hF4240;
            rnd = i % 4;
            source_data[32*sel +: 32] <= x;
            acc(1, 9'h069, y2);
            acc(1, 9'h06A, y3);
            acc(1, 9'h040, {18'h0, sel[5:0], 3'h0, rnd, i < 6, 2'h1});
            wt(3);
            rchk(9'h046, x);
            rchk(9'h047, model(x, rnd));
            check(curve_value[31:0], model(x, rnd));
            check(curve_input_range_fault[0],
                  i < 6 && (x < 0 || x > 32'sh249F0));
        end
        x = 32'h30D40;
        source_data[32*sel +: 32] <= x;
        acc(1, 9'h040, {18'h0, sel[5:0], 8'h05});
        wt(3);
        check(curve_input_range_fault[0], 1'b1);
        check(irq, 1'b1);
        check(|curve_value[127:32], 1'b0);
        check(curve_input_range_fault[3:1], 3'h0);
        rchk(9'h047, y3);
        source_valid[sel] <= 1'b0;
        source_data[32*sel +: 32] <= 32'h4E20;
        wt(3);
        rchk(9'h046, x);
        source_valid[sel] <= 1'b1;
        acc(1, 9'h040, {18'h0, sel[5:0], 8'h04});
        wt(3);
        check(curve_input_range_fault[0], 1'b0);
        rchk(9'h046, x);
        acc(1, `A_GCTRL, 32'h0);
        acc(1, 9'h040, {18'h0, sel[5:0], 8'h05});
        wt(3);
        check(curve_input_range_fault[0], 1'b0);
        rchk(9'h046, x);
        acc(1, `A_IRQ_EN, 32'h0);
        repeat (2) @(negedge clk_sys);
        check(irq, 1'b0);
        @(posedge clk_sys);
        acc(1, `A_IRQ_CLR, 32'hFF);
        rchk(`A_IRQ_STAT, 32'h0);
        acc(1, `A_IRQ_EN, 32'hFF);
        acc(1, 9'h041, 32'h2);
        acc(1, 9'h040, {18'h0, sel[5:0], 8'h03});
        acc(1, `A_GCTRL, 32'h1);
        wt(24);
        acc(0, 9'h046, 32'h0);
        check(rd - 32'h4E20 + 1 <= 2, 1'b1);
        source_data[32*sel +: 32] <= 32'h0;
        wt(2);
        acc(0, 9'h046, 32'h0);
        check(rd > 0 && rd < 32'h4E20, 1'b1);
        acc(1, 9'h042, 32'h64);
        acc(1, 9'h040, {18'h0, sel[5:0], 8'h01});
        source_data[32*sel +: 32] <= 32'h1;
        wt(3);
        rchk(9'h046, 32'h0);
        print_verdict;
    end
endmodule // tb_top
